// *** core/gdcc_config.v ***
// Purpose: configuration register bank of an isolated gate driver
// Assumes: APB slave, zero wait states, 10 MHz core_clk_i
// Notes:   protection detection and framing live outside
`timescale 1ns/100ps
`include "gdcc_defs.vh"

module gdcc_config (
  input  wire             core_clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [11:0]      paddr_i,
  input  wire [31:0]      pwdata_i,
  output reg  [31:0]      prdata_o,
  output wire             pready_o,
  output wire             pslverr_o,
  input  wire             pwm_i,
  input  wire             seq_start_i,
  input  wire             emergency_off_i,
  input  wire             blanking_i,
  input  wire             igbt_state_i,
  input  wire             shutdown_tristate_i,
  input  wire             neg_overvolt_i,
  input  wire             dchan_pin_a_i,
  input  wire             dchan_pin_b_i,
  output reg              state_out_o,
  output wire             stage_monitor_en_o,
  output wire             shutdown_classa_o,
  output wire             tristate_req_o,
  output reg              tristate_error_flag_o,
  output reg              desat_clamp_o,
  output wire             pulse_suppress_en_o,
  output wire             two_level_turn_on_o,
  output wire             two_level_turn_off_o,
  output wire             safe_two_level_off_o,
  output wire [7:0]       ton_delay_o,
  output wire [7:0]       regular_toff_delay_o,
  output wire [7:0]       safe_toff_delay_o,
  output wire [7:0]       safe_plateau_level_o,
  output wire             ocp_blank_en_o,
  output wire [7:0]       overcurrent_blank_time_o,
  output wire [7:0]       desat_blank_time_o,
  output reg              active_clamp_out_o,
  output wire             classb_event_o,
  output wire             classc_event_o,
  output reg              neg_overvolt_error_o,
  output reg  [7:0]       plateau_in_use_o,
  output reg  [7:0]       turn_on_plateau_in_use_o,
  output wire             dchan_a_dir_o,
  output wire             dchan_b_dir_o,
  output wire             dchan_a_level_o,
  output wire             dchan_b_level_o
);

  // ************************************************
  // operating mode states (one-hot)
  // ************************************************
  localparam [1:0] ST_CFG = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  reg [1:0]  st_r;
  reg [2:0]  mode_r;
  reg [7:0]  primary_config_one_r;
  reg [7:0]  primary_config_two_r;
  reg [7:0]  secondary_config_one_r;
  reg [15:0] secondary_config_two_r;
  reg [7:0]  regular_toff_delay_r;
  reg [15:0] safe_toff_r;
  reg [7:0]  ocp_bt_r;
  reg [7:0]  dsat_bt_r;
  reg [7:0]  clamp_time_r;
  reg [7:0]  turn_on_plateau_r;
  reg [7:0]  regular_plateau_request_r;
  reg [7:0]  plateau_echo_r;
  reg [7:0]  sec_rx_r;
  reg        cal_en_r;
  reg [3:0]  xfer_cnt_r;
  reg [7:0]  clamp_cnt_r;
  reg        cfg_open;
  wire       wr;
  wire [`GDCC_CNT_W-1:0] tcf_count;
  wire       tcf_done;

  // ************************************************
  // helpers
  // ************************************************
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == `GDCC_Z8);
    end
  endfunction

  assign wr        = psel_i && penable_i && pwrite_i && ce_i;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;

  always @* begin
    cfg_open = (st_r == ST_CFG);
  end

  // ************************************************
  // mode state and register writes
  // ************************************************
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r                      <= ST_CFG;
      mode_r                    <= `GDCC_MODE_CFG;
      primary_config_one_r      <= `GDCC_PCFG1_RST;
      primary_config_two_r      <= `GDCC_PRIMARY_CONFIG_TWO_RST;
      secondary_config_one_r    <= `GDCC_SCFG1_RST;
      secondary_config_two_r    <= `GDCC_SECONDARY_CONFIG_TWO_RST;
      regular_toff_delay_r      <= `GDCC_Z8;
      safe_toff_r               <= `GDCC_SECONDARY_CONFIG_TWO_RST;
      ocp_bt_r                  <= `GDCC_Z8;
      dsat_bt_r                 <= `GDCC_Z8;
      clamp_time_r              <= `GDCC_Z8;
      turn_on_plateau_r         <= `GDCC_Z8;
      regular_plateau_request_r <= `GDCC_Z8;
      cal_en_r                  <= 1'b0;
    end else if (wr) begin
      case (paddr_i)
        `GDCC_A_MODE: begin
          mode_r <= pwdata_i[`GDCC_F_MODE];
          if (pwdata_i[`GDCC_F_MODE] != `GDCC_MODE_CFG)
            st_r <= ST_RUN;
        end
        `GDCC_A_PCFG1: if (cfg_open)
          primary_config_one_r <= pwdata_i[7:0];
        `GDCC_A_PRIMARY_CONFIG_TWO:
          if (cfg_open && primary_config_one_r[`GDCC_B_UNLOCK])
            primary_config_two_r <= pwdata_i[7:0];
        `GDCC_A_SCFG1: if (cfg_open)
          secondary_config_one_r <= pwdata_i[7:0];
        `GDCC_A_SECONDARY_CONFIG_TWO:
          if (cfg_open && secondary_config_one_r[`GDCC_B_UNLOCK])
            secondary_config_two_r <= pwdata_i[15:0];
        `GDCC_A_RTOFF: if (cfg_open)
          regular_toff_delay_r <= pwdata_i[`GDCC_F_DLY];
        `GDCC_A_STOFF: if (cfg_open)
          safe_toff_r <= pwdata_i[15:0];
        `GDCC_A_OCP: if (cfg_open)
          ocp_bt_r <= pwdata_i[7:0];
        `GDCC_A_DSAT: if (cfg_open)
          dsat_bt_r <= pwdata_i[7:0];
        `GDCC_A_CLT: if (cfg_open)
          clamp_time_r <= pwdata_i[7:0];
        `GDCC_A_SECONDARY_SUPERVISION_CTL: if (cfg_open)
          cal_en_r <= pwdata_i[0];
        `GDCC_A_PCTRL1:
          turn_on_plateau_r <= pwdata_i[7:0];
        `GDCC_A_PRIMARY_CONTROL_TWO:
          regular_plateau_request_r <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ************************************************
  // plateau transfer and latching
  // ************************************************
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xfer_cnt_r               <= `GDCC_XFER_DIV;
      sec_rx_r                 <= `GDCC_Z8;
      plateau_echo_r           <= `GDCC_Z8;
      plateau_in_use_o         <= `GDCC_Z8;
      turn_on_plateau_in_use_o <= `GDCC_Z8;
    end else if (ce_i) begin
      xfer_cnt_r <= xfer_cnt_r - `GDCC_XFER_ONE;
      if (xfer_cnt_r == `GDCC_XFER_ONE) begin
        xfer_cnt_r     <= `GDCC_XFER_DIV;
        sec_rx_r       <= regular_plateau_request_r;
        plateau_echo_r <= sec_rx_r;
      end
      if (seq_start_i) begin
        plateau_in_use_o         <= sec_rx_r;
        turn_on_plateau_in_use_o <= turn_on_plateau_r;
      end
    end
  end

  // ************************************************
  // output options
  // ************************************************
  assign stage_monitor_en_o = !secondary_config_one_r[`GDCC_B_STAGE_MONITOR_DISABLE];
  assign tristate_req_o     = shutdown_tristate_i;
  assign shutdown_classa_o  = shutdown_tristate_i &&
                              !secondary_config_one_r[`GDCC_B_SHUTDOWN_PIN_CLASSA_OFF];
  assign pulse_suppress_en_o  = secondary_config_one_r[`GDCC_B_PULSE_SUPPRESS_EN];
  assign ton_delay_o          = secondary_config_two_r[`GDCC_F_TON_DELAY_FIELD];
  assign two_level_turn_on_o  = !is_zero(ton_delay_o);
  assign regular_toff_delay_o = regular_toff_delay_r;
  assign safe_toff_delay_o    = safe_toff_r[`GDCC_F_DLY];
  assign safe_plateau_level_o = safe_toff_r[`GDCC_F_GPS];
  assign two_level_turn_off_o = !is_zero(regular_toff_delay_r);
  assign safe_two_level_off_o = !is_zero(safe_toff_delay_o);
  assign overcurrent_blank_time_o = ocp_bt_r;
  assign ocp_blank_en_o     = !is_zero(ocp_bt_r);
  assign desat_blank_time_o = dsat_bt_r;
  assign classb_event_o = neg_overvolt_i &&
                          !secondary_config_two_r[`GDCC_B_OVLO];
  assign classc_event_o = neg_overvolt_i &&
                          secondary_config_two_r[`GDCC_B_OVLO];
  assign dchan_a_dir_o  = primary_config_two_r[`GDCC_B_DIR];
  assign dchan_b_dir_o  = secondary_config_two_r[`GDCC_B_DIR];

  // ************************************************
  // registered outputs: state, clamps, flags
  // ************************************************
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_out_o           <= 1'b0;
      desat_clamp_o         <= 1'b1;
      tristate_error_flag_o <= 1'b0;
      neg_overvolt_error_o  <= 1'b0;
      active_clamp_out_o    <= 1'b1;
      clamp_cnt_r           <= `GDCC_Z8;
    end else if (ce_i) begin
      state_out_o <= primary_config_two_r[`GDCC_B_DOEN] &&
                     igbt_state_i;
      desat_clamp_o <= blanking_i ||
                       (secondary_config_one_r[`GDCC_B_PERM_DESAT_CLAMP_EN] &&
                        !pwm_i);
      if (shutdown_tristate_i)
        tristate_error_flag_o <= 1'b1;
      if (neg_overvolt_i)
        neg_overvolt_error_o <= 1'b1;
      if (is_zero(clamp_time_r)) begin
        active_clamp_out_o <= 1'b1;
      end else if (clamp_time_r == `GDCC_FF8) begin
        active_clamp_out_o <= 1'b0;
      end else if (seq_start_i && !pwm_i &&
                   (!secondary_config_two_r[`GDCC_B_CLAMP_MODE_BIT] ||
                    emergency_off_i)) begin
        clamp_cnt_r        <= clamp_time_r;
        active_clamp_out_o <= 1'b0;
      end else if (!is_zero(clamp_cnt_r)) begin
        clamp_cnt_r <= clamp_cnt_r - 8'h01;
        if (clamp_cnt_r == 8'h01)
          active_clamp_out_o <= 1'b1;
      end else begin
        active_clamp_out_o <= 1'b1;
      end
    end
  end

  // ************************************************
  // calibration counter and channel filters
  // ************************************************
  gdcc_tcf_counter u_tcf (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .en_i       (cal_en_r && (mode_r == `GDCC_MODE_CAL)),
    .pwm_i      (pwm_i),
    .count_o    (tcf_count),
    .done_o     (tcf_done)
  );

  gdcc_debounce u_deb_a (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .din_i      (dchan_pin_a_i),
    .level_o    (dchan_a_level_o)
  );

  gdcc_debounce u_deb_b (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .din_i      (dchan_pin_b_i),
    .level_o    (dchan_b_level_o)
  );

  // ************************************************
  // APB read path
  // ************************************************
  always @* begin
    prdata_o = 32'h0000_0000;
    case (paddr_i)
      `GDCC_A_PCFG1:  prdata_o[7:0]  = primary_config_one_r;
      `GDCC_A_PRIMARY_CONFIG_TWO:  prdata_o[7:0]  = primary_config_two_r;
      `GDCC_A_SCFG1:  prdata_o[7:0]  = secondary_config_one_r;
      `GDCC_A_SECONDARY_CONFIG_TWO:  prdata_o[15:0] = secondary_config_two_r;
      `GDCC_A_RTOFF:  prdata_o[7:0]  = regular_toff_delay_r;
      `GDCC_A_STOFF:  prdata_o[15:0] = safe_toff_r;
      `GDCC_A_OCP:    prdata_o[7:0]  = ocp_bt_r;
      `GDCC_A_DSAT:   prdata_o[7:0]  = dsat_bt_r;
      `GDCC_A_CLT:    prdata_o[7:0]  = clamp_time_r;
      `GDCC_A_PCTRL1: prdata_o[7:0]  = turn_on_plateau_r;
      `GDCC_A_PRIMARY_CONTROL_TWO: prdata_o[7:0]  = regular_plateau_request_r;
      `GDCC_A_PRIMARY_STATUS:  prdata_o[7:0]  = plateau_echo_r;
      `GDCC_A_SECONDARY_CONTROL:  prdata_o[7:0]  = plateau_in_use_o;
      `GDCC_A_SECONDARY_SUPERVISION_CTL:   prdata_o[0]    = cal_en_r;
      `GDCC_A_PRIMARY_PIN_STATUS:   prdata_o[0]    = dchan_a_level_o;
      `GDCC_A_SECONDARY_STATUS_TWO: prdata_o[0]    = dchan_b_level_o;
      `GDCC_A_TCNT:   prdata_o       = {tcf_done, 15'h0000, tcf_count};
      `GDCC_A_MODE:   prdata_o[2:0]  = mode_r;
      default:        prdata_o       = 32'h0000_0000;
    endcase
  end

endmodule // gdcc_config

// *** core/gdcc_defs.vh ***
// Purpose: constants of the gate driver configuration block
// Assumes: APB word registers, byte addresses
// Notes:   included by all design files
`ifndef GDCC_DEFS_VH
`define GDCC_DEFS_VH

// ************************************************
// register byte addresses
// ************************************************
`define GDCC_A_PCFG1   12'h000
`define GDCC_A_PRIMARY_CONFIG_TWO   12'h004
`define GDCC_A_SCFG1   12'h008
`define GDCC_A_SECONDARY_CONFIG_TWO   12'h00C
`define GDCC_A_RTOFF   12'h010
`define GDCC_A_STOFF   12'h014
`define GDCC_A_OCP     12'h018
`define GDCC_A_DSAT    12'h01C
`define GDCC_A_CLT     12'h020
`define GDCC_A_PCTRL1  12'h024
`define GDCC_A_PRIMARY_CONTROL_TWO  12'h028
`define GDCC_A_PRIMARY_STATUS   12'h02C
`define GDCC_A_SECONDARY_CONTROL   12'h030
`define GDCC_A_SECONDARY_SUPERVISION_CTL    12'h034
`define GDCC_A_PRIMARY_PIN_STATUS    12'h038
`define GDCC_A_SECONDARY_STATUS_TWO  12'h03C
`define GDCC_A_TCNT    12'h040
`define GDCC_A_MODE    12'h044

// ************************************************
// field positions
// ************************************************
`define GDCC_B_UNLOCK   0
`define GDCC_B_DOEN     1
`define GDCC_B_DIR      2
`define GDCC_B_STATE_MONITOR_ENABLE    1
`define GDCC_B_PERM_DESAT_CLAMP_EN   2
`define GDCC_B_STAGE_MONITOR_DISABLE     3
`define GDCC_B_SHUTDOWN_PIN_CLASSA_OFF    4
`define GDCC_B_PULSE_SUPPRESS_EN     5
`define GDCC_B_CLAMP_MODE_BIT    3
`define GDCC_B_OVLO     4
`define GDCC_F_TON_DELAY_FIELD    15:8
`define GDCC_F_DLY      7:0
`define GDCC_F_GPS      15:8
`define GDCC_F_MODE     2:0

// ************************************************
// widths, reset values, codes
// ************************************************
`define GDCC_W          8
`define GDCC_Z8         8'h00
`define GDCC_FF8        8'hFF
`define GDCC_PCFG1_RST  8'h00
`define GDCC_PRIMARY_CONFIG_TWO_RST  8'h02
`define GDCC_SCFG1_RST  8'h00
`define GDCC_SECONDARY_CONFIG_TWO_RST  16'h0000
`define GDCC_MODE_CFG   3'h2
`define GDCC_MODE_CAL   3'h6
`define GDCC_SYNC_RST   2'h0
`define GDCC_CNT_W      16
`define GDCC_CNT_ONE    16'h0001
`define GDCC_CNT_ZERO   16'h0000
`define GDCC_XFER_DIV   4'hF
`define GDCC_XFER_ONE   4'h1

`endif

// *** core/gdcc_debounce.v ***
// Purpose: two-sample debounce of a digital channel input
// Assumes: input synchronous to core_clk_i
// Notes:   level accepted after two equal consecutive samples
`timescale 1ns/100ps
`include "gdcc_defs.vh"

module gdcc_debounce (
  input  wire core_clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire din_i,
  output reg  level_o
);

  reg [1:0] smp_r;

  // ************************************************
  // sampling and acceptance
  // ************************************************
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      smp_r   <= `GDCC_SYNC_RST;
      level_o <= 1'b0;
    end else if (ce_i) begin
      smp_r <= {smp_r[0], din_i};
      if (smp_r[1] == smp_r[0])
        level_o <= smp_r[1];
    end
  end

endmodule // gdcc_debounce

// *** core/gdcc_tcf_counter.v ***
// Purpose: timing calibration counter
// Assumes: pwm_i synchronous to core_clk_i
// Notes:   counts while pwm high when enabled; restarts on rising pwm
`timescale 1ns/100ps
`include "gdcc_defs.vh"

module gdcc_tcf_counter (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   en_i,
  input  wire                   pwm_i,
  output reg  [`GDCC_CNT_W-1:0] count_o,
  output reg                    done_o
);

  reg pwm_d_r;

  // ************************************************
  // start on rising pwm, stop on falling pwm
  // ************************************************
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_d_r <= 1'b0;
      count_o <= `GDCC_CNT_ZERO;
      done_o  <= 1'b0;
    end else if (ce_i) begin
      pwm_d_r <= pwm_i;
      if (en_i) begin
        if (pwm_i && !pwm_d_r) begin
          count_o <= `GDCC_CNT_ONE;
          done_o  <= 1'b0;
        end else if (pwm_i && !done_o) begin
          count_o <= count_o + `GDCC_CNT_ONE;
        end else if (!pwm_i && pwm_d_r) begin
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // gdcc_tcf_counter

// *** tb/gdcc_config_props.sv ***
// Purpose: port level checks of the config block
// Assumes: ce_i held high by the bench
// Notes:   bound into every gdcc_config instance
`timescale 1ns/100ps
module gdcc_config_props (
  input wire       core_clk_i,
  input wire       rst_i,
  input wire       pready_o,
  input wire       pslverr_o,
  input wire       pwm_i,
  input wire       seq_start_i,
  input wire       blanking_i,
  input wire       igbt_state_i,
  input wire       shutdown_tristate_i,
  input wire       neg_overvolt_i,
  input wire       dchan_pin_a_i,
  input wire       state_out_o,
  input wire       shutdown_classa_o,
  input wire       tristate_req_o,
  input wire       tristate_error_flag_o,
  input wire       desat_clamp_o,
  input wire       two_level_turn_on_o,
  input wire       two_level_turn_off_o,
  input wire       safe_two_level_off_o,
  input wire       ocp_blank_en_o,
  input wire       classb_event_o,
  input wire       classc_event_o,
  input wire       neg_overvolt_error_o,
  input wire       dchan_a_level_o,
  input wire [7:0] ton_delay_o,
  input wire [7:0] regular_toff_delay_o,
  input wire [7:0] safe_toff_delay_o,
  input wire [7:0] overcurrent_blank_time_o,
  input wire [7:0] plateau_in_use_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // ****************
  // assertions
  // ****************
  apb_answer_a: assert property (pready_o && !pslverr_o)
    else $error("bus answer late or in error");
  trist_req_a: assert property (
    tristate_req_o == shutdown_tristate_i)
    else $error("tristate request not following event");
  classa_cause_a: assert property (
    shutdown_classa_o |-> shutdown_tristate_i)
    else $error("class A event without cause");
  trist_flag_a: assert property (
    shutdown_tristate_i |=> tristate_error_flag_o)
    else $error("tristate flag not set");
  clamp_blank_a: assert property (blanking_i |=> desat_clamp_o)
    else $error("no clamp in blanking");
  clamp_free_a: assert property (
    !blanking_i && pwm_i |=> !desat_clamp_o)
    else $error("clamp during on command");
  state_out_a: assert property (state_out_o |-> $past(igbt_state_i))
    else $error("state output without state");
  ton_hard_a: assert property (
    two_level_turn_on_o == (ton_delay_o != 8'h00))
    else $error("turn on mode wrong");
  toff_hard_a: assert property ((two_level_turn_off_o ==
    (regular_toff_delay_o != 8'h00)) &&
    (safe_two_level_off_o == (safe_toff_delay_o != 8'h00)))
    else $error("turn off mode wrong");
  ocp_blank_a: assert property (
    ocp_blank_en_o == (overcurrent_blank_time_o != 8'h00))
    else $error("ocp blanking enable wrong");
  ovlo_class_a: assert property (
    neg_overvolt_i == (classb_event_o ^ classc_event_o))
    else $error("over-voltage class wrong");
  ovlo_flag_a: assert property (
    neg_overvolt_i |=> neg_overvolt_error_o)
    else $error("over-voltage flag not set");
  plat_latch_a: assert property (
    !$stable(plateau_in_use_o) |-> $past(seq_start_i))
    else $error("plateau changed outside sequence start");
  deb_level_a: assert property (
    $stable(dchan_pin_a_i) [*6] |-> dchan_a_level_o == dchan_pin_a_i)
    else $error("debounced level stale");
  cover property (seq_start_i ##1 !$stable(plateau_in_use_o));
  cover property (shutdown_tristate_i && !shutdown_classa_o);
  cover property (classc_event_o);
endmodule // gdcc_config_props

bind gdcc_config gdcc_config_props u_props (.*);

// *** tb/gdcc_host_model.sv ***
// Purpose: host side bus master of the config block
// Assumes: called from the bench process
// Notes:   released lines show inverted values
`timescale 1ns/100ps
module gdcc_host_model (
  input  wire        core_clk_i,
  input  wire        pready_i,
  input  wire [31:0] prdata_i,
  output reg         psel_o,
  output reg         penable_o,
  output reg         pwrite_o,
  output reg  [11:0] paddr_o,
  output reg  [31:0] pwdata_o
);
  initial begin
    psel_o = 1'h0;
    penable_o = 1'h0;
    pwrite_o = 1'h0;
    paddr_o = 12'h0;
    pwdata_o = 32'h0;
  end
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge core_clk_i);
      psel_o <= 1'h1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge core_clk_i) penable_o <= 1'h1;
      @(posedge core_clk_i);
      while (pready_i !== 1'h1) @(posedge core_clk_i);
      q = prdata_i;
      psel_o <= 1'h0;
      penable_o <= 1'h0;
      pwrite_o <= ~w;
      paddr_o <= ~a;
      pwdata_o <= ~d;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    reg [31:0] q;
    begin
      xfer(1'h1, a, d, q);
    end
  endtask
  task rd(input [11:0] a, output [31:0] q);
    begin
      xfer(1'h0, a, 32'hA5A5A5A5, q);
    end
  endtask
endmodule // gdcc_host_model

// *** tb/gdcc_config_test.sv ***
// Purpose: self-checking bench of the config block
// Assumes: ce_i held high, host model issues bus cycles
// Notes:   inputs change on rising edges, checks after cy on falling, after register reads on rising
`timescale 1ns/100ps
`include "gdcc_defs.vh"
module gdcc_config_test;
  reg         core_clk_i, rst_i, ce_i, pwm_i, seq_start_i;
  reg         emergency_off_i, blanking_i, igbt_state_i;
  reg         shutdown_tristate_i, neg_overvolt_i;
  reg         dchan_pin_a_i, dchan_pin_b_i;
  wire        psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  wire [11:0] paddr_i;
  wire [31:0] pwdata_i, prdata_o;
  wire        state_out_o, stage_monitor_en_o, shutdown_classa_o;
  wire        tristate_req_o, tristate_error_flag_o, desat_clamp_o;
  wire        pulse_suppress_en_o, two_level_turn_on_o, ocp_blank_en_o;
  wire        two_level_turn_off_o, safe_two_level_off_o;
  wire        active_clamp_out_o, classb_event_o, classc_event_o;
  wire        neg_overvolt_error_o, dchan_a_dir_o, dchan_b_dir_o;
  wire        dchan_a_level_o, dchan_b_level_o;
  wire [7:0]  ton_delay_o, regular_toff_delay_o, safe_toff_delay_o;
  wire [7:0]  safe_plateau_level_o, overcurrent_blank_time_o;
  wire [7:0]  desat_blank_time_o, plateau_in_use_o;
  wire [7:0]  turn_on_plateau_in_use_o;
  reg  [31:0] v;
  integer     n_mismatch, checks_done, i;

  gdcc_config dut (.*);
  gdcc_host_model host (
    .core_clk_i (core_clk_i),
    .pready_i   (pready_o),
    .prdata_i   (prdata_o),
    .psel_o     (psel_i),
    .penable_o  (penable_i),
    .pwrite_o   (pwrite_i),
    .paddr_o    (paddr_i),
    .pwdata_o   (pwdata_i)
  );
  // ****************
  // helpers
  // ****************
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task rc(input [11:0] a, input [31:0] e);
    begin
      host.rd(a, v);
      chk(v, e);
    end
  endtask
  task cy(input integer n);
    begin
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
    end
  endtask
  task sq;
    begin
      @(posedge core_clk_i) seq_start_i <= 1'h1;
      @(posedge core_clk_i) seq_start_i <= 1'h0;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    core_clk_i = 1'h0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
  // ****************
  // tests
  // ****************
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    {rst_i, ce_i, pwm_i, seq_start_i} = 4'hC;
    {emergency_off_i, blanking_i, igbt_state_i} = 3'h0;
    {shutdown_tristate_i, neg_overvolt_i} = 2'h0;
    {dchan_pin_a_i, dchan_pin_b_i} = 2'h0;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'h0;
    rc(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h2);
    rc(`GDCC_A_SCFG1, 32'h0);
    rc(`GDCC_A_MODE, 32'h2);
    host.wr(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h0);
    host.wr(`GDCC_A_SECONDARY_CONFIG_TWO, 32'h3000);
    rc(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h2);
    rc(`GDCC_A_SECONDARY_CONFIG_TWO, 32'h0);
    host.wr(`GDCC_A_PCFG1, 32'h1);
    host.wr(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h6);
    host.wr(`GDCC_A_SCFG1, 32'h23);
    host.wr(`GDCC_A_RTOFF, 32'h20);
    host.wr(`GDCC_A_SECONDARY_CONFIG_TWO, 32'h4);
    rc(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h6);
    rc(`GDCC_A_SECONDARY_CONFIG_TWO, 32'h4);
    chk({two_level_turn_on_o, dchan_a_dir_o,
         dchan_b_dir_o}, 3'h3);
    @(posedge core_clk_i) igbt_state_i <= 1'h1;
    cy(2);
    chk(state_out_o, 1'h1);
    host.wr(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h4);
    cy(2);
    chk(state_out_o, 1'h0);
    host.wr(`GDCC_A_SCFG1, 32'h2B);
    cy(1);
    chk({stage_monitor_en_o, pulse_suppress_en_o}, 2'h1);
    @(posedge core_clk_i) shutdown_tristate_i <= 1'h1;
    cy(0);
    chk(shutdown_classa_o, 1'h1);
    @(posedge core_clk_i) shutdown_tristate_i <= 1'h0;
    host.wr(`GDCC_A_SCFG1, 32'h33);
    @(posedge core_clk_i) shutdown_tristate_i <= 1'h1;
    cy(2);
    chk({shutdown_classa_o, tristate_req_o}, 2'h1);
    chk({tristate_error_flag_o, stage_monitor_en_o}, 2'h3);
    @(posedge core_clk_i) shutdown_tristate_i <= 1'h0;
    for (i = 0; i < 8; i = i + 1) begin
      host.wr(`GDCC_A_SCFG1, i[2] ? 32'h37 : 32'h33);
      pwm_i <= i[1];
      blanking_i <= i[0];
      cy(2);
      chk(desat_clamp_o, i[0] | (i[2] & ~i[1]));
    end
    host.wr(`GDCC_A_CLT, 32'h0);
    pwm_i <= 1'h0;
    blanking_i <= 1'h0;
    sq;
    cy(1);
    chk(active_clamp_out_o, 1'h1);
    host.wr(`GDCC_A_CLT, 32'hFF);
    cy(2);
    chk(active_clamp_out_o, 1'h0);
    host.wr(`GDCC_A_CLT, 32'h4);
    sq;
    cy(1);
    chk(active_clamp_out_o, 1'h0);
    cy(8);
    chk(active_clamp_out_o, 1'h1);
    host.wr(`GDCC_A_SECONDARY_CONFIG_TWO, 32'hC);
    sq;
    cy(1);
    chk(active_clamp_out_o, 1'h1);
    @(posedge core_clk_i) emergency_off_i <= 1'h1;
    sq;
    cy(1);
    chk(active_clamp_out_o, 1'h0);
    cy(8);
    @(posedge core_clk_i) neg_overvolt_i <= 1'h1;
    cy(1);
    chk({classb_event_o, classc_event_o,
         neg_overvolt_error_o}, 3'h5);
    host.wr(`GDCC_A_SECONDARY_CONFIG_TWO, 32'h301C);
    cy(0);
    chk({classb_event_o, classc_event_o}, 2'h1);
    chk({ton_delay_o, two_level_turn_on_o}, 9'h61);
    @(posedge core_clk_i) neg_overvolt_i <= 1'h0;
    host.wr(`GDCC_A_STOFF, 32'h1840);
    host.wr(`GDCC_A_OCP, 32'h5);
    host.wr(`GDCC_A_DSAT, 32'h10);
    cy(0);
    chk({regular_toff_delay_o, safe_toff_delay_o}, 16'h2040);
    chk({safe_plateau_level_o, desat_blank_time_o,
         overcurrent_blank_time_o}, 24'h181005);
    chk({two_level_turn_off_o, safe_two_level_off_o,
         ocp_blank_en_o}, 3'h7);
    host.wr(`GDCC_A_RTOFF, 32'h0);
    host.wr(`GDCC_A_OCP, 32'h0);
    cy(0);
    chk({two_level_turn_off_o, safe_two_level_off_o,
         ocp_blank_en_o}, 3'h2);
    host.wr(`GDCC_A_RTOFF, 32'h20);
    host.wr(`GDCC_A_SECONDARY_SUPERVISION_CTL, 32'h1);
    host.wr(`GDCC_A_MODE, 32'h6);
    @(posedge core_clk_i) pwm_i <= 1'h1;
    cy(20);
    @(posedge core_clk_i) pwm_i <= 1'h0;
    cy(2);
    host.rd(`GDCC_A_TCNT, v);
    chk(v[31], 1'h1);
    chk(v[15:0], 16'h15);
    host.wr(`GDCC_A_SCFG1, 32'h0);
    host.wr(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h6);
    rc(`GDCC_A_SCFG1, 32'h37);
    rc(`GDCC_A_PRIMARY_CONFIG_TWO, 32'h4);
    host.wr(`GDCC_A_PRIMARY_CONTROL_TWO, 32'h33);
    host.wr(`GDCC_A_PCTRL1, 32'h44);
    cy(40);
    rc(`GDCC_A_PRIMARY_STATUS, 32'h33);
    chk(plateau_in_use_o, 8'h0);
    sq;
    cy(1);
    chk({plateau_in_use_o, turn_on_plateau_in_use_o}, 16'h3344);
    rc(`GDCC_A_SECONDARY_CONTROL, 32'h33);
    @(posedge core_clk_i) dchan_pin_a_i <= 1'h1;
    @(posedge core_clk_i) dchan_pin_a_i <= 1'h0;
    cy(6);
    chk(dchan_a_level_o, 1'h0);
    @(posedge core_clk_i) dchan_pin_a_i <= 1'h1;
    dchan_pin_b_i <= 1'h1;
    cy(6);
    rc(`GDCC_A_PRIMARY_PIN_STATUS, 32'h1);
    rc(`GDCC_A_SECONDARY_STATUS_TWO, 32'h1);
    host.wr(12'h100, 32'hFF);
    rc(12'h100, 32'h0);
    test_done;
  end
endmodule // gdcc_config_test
